// *** hdl/ple_link.sv ***
`timescale 1ns/1ps
`default_nettype none
module ple_link #(
  parameter int MS_CYCLES = ple_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Host CPU
  input  wire logic [1:0]  i_cpu_mode,
  input  wire logic        i_scan_end,
  input  wire logic [5:0]  i_local_station,
  // Send request
  output logic             o_tx_valid,
  input  wire logic        i_tx_ready,
  output logic [5:0]       o_tx_station,
  output logic [4:0]       o_tx_block,
  output logic [1:0]       o_tx_area,
  output logic [13:0]      o_tx_offset,
  output logic [7:0]       o_tx_words,
  // Received block header
  input  wire logic        i_rx_valid,
  input  wire logic [5:0]  i_rx_station,
  input  wire logic [4:0]  i_rx_block,
  input  wire logic [7:0]  i_rx_words,
  output logic             o_rx_hit,
  output logic             o_rx_drop,
  output logic [1:0]       o_rx_area,
  output logic [13:0]      o_rx_offset,
  output logic [7:0]       o_rx_keep,
  // Link indications
  output logic             o_run_link,
  output logic             o_link_trouble,
  output logic [63:0]      o_entry_status_bits
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [63:0]       vld;
    logic [63:0]       dir;
    logic [63:0][5:0]  stn;
    logic [63:0][4:0]  blk;
    logic [63:0][1:0]  area;
    logic [63:0][7:0]  size;
    logic [63:0][13:0] per;
    logic [63:0][13:0] ofs;
    logic [63:0][14:0] tmr;
    logic [63:0]       got;
    logic [63:0]       pend;
    logic [63:0]       stat;
    logic [63:0]       seen;
    logic [5:0]        sel;
    logic [5:0]        rr;
    logic              en;
    logic              run;
    logic              tx_vld;
    logic [5:0]        tx_stn;
    logic [4:0]        tx_blk;
    logic [1:0]        tx_area;
    logic [13:0]       tx_ofs;
    logic [7:0]        tx_words;
    logic              rx_hit;
    logic              rx_drop;
    logic [1:0]        rx_area;
    logic [13:0]       rx_ofs;
    logic [7:0]        rx_keep;
  } ple_st_t;

  ple_st_t     st_ff;
  ple_st_t     nxt_st;
  logic        ms_tick;
  logic [63:0] rx_req;
  logic        rx_found;
  logic [5:0]  rx_idx;
  logic        tx_found;
  logic [5:0]  tx_idx;
  logic [6:0]  n_send;
  logic [6:0]  n_recv;
  logic        cfg_err;
  logic        act;
  logic        wr;

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  ple_ms_tick #(
    .CYCLES (MS_CYCLES)
  ) u_tick (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .o_tick  (ms_tick)
  );

  // Receive lookup; unique station/block pairs assumed
  ple_pick u_rx_pick (
    .i_req   (rx_req),
    .i_start (6'h00),
    .o_hit   (rx_found),
    .o_idx   (rx_idx)
  );

  // Send arbitration rotates past the last sender
  ple_pick u_tx_pick (
    .i_req   (st_ff.pend),
    .i_start (st_ff.rr),
    .o_hit   (tx_found),
    .o_idx   (tx_idx)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [14:0] p;
    p = 15'h0000;
    nxt_st = st_ff;
    nxt_st.rx_hit = 1'b0;
    nxt_st.rx_drop = 1'b0;
    wr = i_psel & i_penable & i_pwrite;
    // Direction counts and entry sanity
    n_send = ple_pkg::ple_popcount(st_ff.vld & ~st_ff.dir);
    n_recv = ple_pkg::ple_popcount(st_ff.vld & st_ff.dir);
    cfg_err = (n_send > ple_pkg::MAX_DIR) | (n_recv > ple_pkg::MAX_DIR);
    for (int i = 0; i < 64; i++)
    begin
      if (st_ff.vld[i] && (st_ff.area[i] == 2'h3))
      begin
        cfg_err = 1'b1;
      end
      if (st_ff.vld[i] && (st_ff.size[i] > ple_pkg::MAX_WORDS))
      begin
        cfg_err = 1'b1;
      end
    end
    // CPU mode does not gate act; enable writes need CPU_STOP
    act = st_ff.en & ~cfg_err;
    // Register writes
    if (wr)
    begin
      unique case (i_paddr)
        ple_pkg::OFS_CTRL:
        begin
          if (i_cpu_mode == ple_pkg::CPU_STOP)
          begin
            nxt_st.en = i_pwdata[ple_pkg::CTRL_EN];
          end
        end
        ple_pkg::OFS_SEL:
        begin
          nxt_st.sel = i_pwdata[5:0];
        end
        ple_pkg::OFS_CFG:
        begin
          nxt_st.vld[st_ff.sel] = i_pwdata[ple_pkg::CFG_VLD];
          nxt_st.dir[st_ff.sel] = i_pwdata[ple_pkg::CFG_DIR];
          nxt_st.stn[st_ff.sel] = i_pwdata[ple_pkg::CFG_STN_LSB +: 6];
          nxt_st.blk[st_ff.sel] = i_pwdata[ple_pkg::CFG_BLK_LSB +: 5];
          nxt_st.area[st_ff.sel] = i_pwdata[ple_pkg::CFG_AREA_LSB +: 2];
          nxt_st.size[st_ff.sel] = i_pwdata[ple_pkg::CFG_SIZE_LSB +: 8];
          nxt_st.en = 1'b0;
        end
        ple_pkg::OFS_TIME:
        begin
          nxt_st.per[st_ff.sel] = i_pwdata[ple_pkg::TIME_PER_LSB +: 14];
          nxt_st.ofs[st_ff.sel] = i_pwdata[ple_pkg::TIME_OFS_LSB +: 14];
          nxt_st.en = 1'b0;
        end
        default:
        begin
          nxt_st.sel = st_ff.sel;
        end
      endcase
    end
    // Receive match on station and block
    for (int i = 0; i < 64; i++)
    begin
      rx_req[i] = i_rx_valid & act & st_ff.vld[i] & st_ff.dir[i]
                  & (st_ff.stn[i] == i_rx_station) & (st_ff.blk[i] == i_rx_block);
    end
    if (i_rx_valid && act)
    begin
      if (rx_found)
      begin
        nxt_st.rx_hit = 1'b1;
        nxt_st.rx_area = st_ff.area[rx_idx];
        nxt_st.rx_ofs = st_ff.ofs[rx_idx];
        nxt_st.rx_keep = (i_rx_words < st_ff.size[rx_idx]) ? i_rx_words
                                                           : st_ff.size[rx_idx];
        nxt_st.got[rx_idx] = 1'b1;
      end
      else
      begin
        nxt_st.rx_drop = 1'b1;
      end
    end
    // Per-entry timers and status
    for (int i = 0; i < 64; i++)
    begin
      p = ple_pkg::ple_eff_period(st_ff.per[i]);
      if (act && st_ff.vld[i])
      begin
        if (ms_tick && (st_ff.tmr[i] != ple_pkg::TMR_MAX))
        begin
          nxt_st.tmr[i] = st_ff.tmr[i] + 15'h0001;
        end
        if (!st_ff.dir[i])
        begin
          if (i_scan_end && (st_ff.tmr[i] >= p))
          begin
            nxt_st.pend[i] = 1'b1;
          end
          if (st_ff.tmr[i] >= (p + p))
          begin
            nxt_st.stat[i] = 1'b0;
          end
        end
        else if (st_ff.tmr[i] >= p)
        begin
          // Interval closes; a block arriving now still counts
          nxt_st.stat[i] = st_ff.got[i] | rx_req[i];
          nxt_st.got[i] = 1'b0;
          nxt_st.tmr[i] = 15'h0000;
          nxt_st.seen[i] = 1'b1;
        end
      end
      else
      begin
        nxt_st.tmr[i] = 15'h0000;
        nxt_st.pend[i] = 1'b0;
        nxt_st.stat[i] = 1'b0;
        nxt_st.got[i] = 1'b0;
        nxt_st.seen[i] = 1'b0;
      end
    end
    // Send handshake, request held until taken
    if (st_ff.tx_vld && i_tx_ready)
    begin
      nxt_st.tx_vld = 1'b0;
    end
    if (!st_ff.tx_vld && tx_found && act)
    begin
      nxt_st.tx_vld = 1'b1;
      nxt_st.tx_stn = i_local_station;
      nxt_st.tx_blk = st_ff.blk[tx_idx];
      nxt_st.tx_area = st_ff.area[tx_idx];
      nxt_st.tx_ofs = st_ff.ofs[tx_idx];
      nxt_st.tx_words = st_ff.size[tx_idx];
      nxt_st.pend[tx_idx] = 1'b0;
      nxt_st.tmr[tx_idx] = 15'h0000;
      nxt_st.stat[tx_idx] = 1'b1;
      nxt_st.seen[tx_idx] = 1'b1;
      nxt_st.rr = tx_idx + 6'h01;
    end
    // Run-link latches until enable drops
    if (!st_ff.en)
    begin
      nxt_st.run = 1'b0;
    end
    else if (act && (|st_ff.vld) && (&(st_ff.stat | ~st_ff.vld))
             && (&(st_ff.seen | ~st_ff.vld)))
    begin
      nxt_st.run = 1'b1;
    end
    // Register reads
    o_pready = 1'b1;
    o_pslverr = 1'b0;
    o_prdata = 32'h0000_0000;
    unique case (i_paddr)
      ple_pkg::OFS_CTRL:
      begin
        o_prdata[ple_pkg::CTRL_EN] = st_ff.en;
      end
      ple_pkg::OFS_STATUS:
      begin
        o_prdata[ple_pkg::ST_RUN] = st_ff.run;
        o_prdata[ple_pkg::ST_TRBL] = ~st_ff.run;
        o_prdata[ple_pkg::ST_CFGERR] = cfg_err;
        o_prdata[ple_pkg::ST_NSEND_LSB +: 7] = n_send;
        o_prdata[ple_pkg::ST_NRECV_LSB +: 7] = n_recv;
      end
      ple_pkg::OFS_SEL:
      begin
        o_prdata[5:0] = st_ff.sel;
      end
      ple_pkg::OFS_CFG:
      begin
        o_prdata[ple_pkg::CFG_VLD] = st_ff.vld[st_ff.sel];
        o_prdata[ple_pkg::CFG_DIR] = st_ff.dir[st_ff.sel];
        o_prdata[ple_pkg::CFG_STN_LSB +: 6] = st_ff.stn[st_ff.sel];
        o_prdata[ple_pkg::CFG_BLK_LSB +: 5] = st_ff.blk[st_ff.sel];
        o_prdata[ple_pkg::CFG_AREA_LSB +: 2] = st_ff.area[st_ff.sel];
        o_prdata[ple_pkg::CFG_SIZE_LSB +: 8] = st_ff.size[st_ff.sel];
      end
      ple_pkg::OFS_TIME:
      begin
        o_prdata[ple_pkg::TIME_PER_LSB +: 14] = st_ff.per[st_ff.sel];
        o_prdata[ple_pkg::TIME_OFS_LSB +: 14] = st_ff.ofs[st_ff.sel];
      end
      ple_pkg::OFS_STLO:
      begin
        o_prdata = st_ff.stat[31:0];
      end
      ple_pkg::OFS_STHI:
      begin
        o_prdata = st_ff.stat[63:32];
      end
      default:
      begin
        o_pslverr = i_psel & i_penable;
      end
    endcase
  end

  // ----------------------------------------
  // Registers; only the backup-loss reset clears them
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Outputs
  assign o_tx_valid = st_ff.tx_vld;
  assign o_tx_station = st_ff.tx_stn;
  assign o_tx_block = st_ff.tx_blk;
  assign o_tx_area = st_ff.tx_area;
  assign o_tx_offset = st_ff.tx_ofs;
  assign o_tx_words = st_ff.tx_words;
  assign o_rx_hit = st_ff.rx_hit;
  assign o_rx_drop = st_ff.rx_drop;
  assign o_rx_area = st_ff.rx_area;
  assign o_rx_offset = st_ff.rx_ofs;
  assign o_rx_keep = st_ff.rx_keep;
  assign o_run_link = st_ff.run;
  assign o_link_trouble = ~st_ff.run;
  assign o_entry_status_bits = st_ff.stat;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  chk_trouble_inverse: assert property (o_link_trouble == !o_run_link)
    else $error("link trouble not inverse of run link");
  chk_run_sticky: assert property (o_run_link && st_ff.en |=> o_run_link)
    else $error("run link dropped while enabled");
  chk_enable_stop: assert property ($rose(st_ff.en) |-> $past(i_cpu_mode) == ple_pkg::CPU_STOP)
    else $error("link enabled outside stop mode");
  chk_download_clear: assert property (wr && i_paddr == ple_pkg::OFS_CFG |=> !st_ff.en)
    else $error("download left link enabled");
  chk_tx_station: assert property ($rose(o_tx_valid) |-> o_tx_station == $past(i_local_station))
    else $error("send block without local station");
  chk_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_block))
    else $error("send request changed before taken");
  chk_cfg_block: assert property (cfg_err |=> !$rose(o_tx_valid))
    else $error("send started under config error");
  chk_rx_drop: assert property (i_rx_valid && act && !rx_found |=> o_rx_drop && !o_rx_hit)
    else $error("unmatched block not dropped");
  chk_rx_keep: assert property (o_rx_hit |-> o_rx_keep <= $past(i_rx_words))
    else $error("kept more words than received");

  cov_run_link: cover property ($rose(o_run_link));
  cov_tx_taken: cover property (o_tx_valid && i_tx_ready);
  cov_rx_hit: cover property (o_rx_hit);
  cov_rx_drop: cover property (o_rx_drop);

endmodule
`default_nettype wire

// *** hdl/ple_ms_tick.sv ***
`timescale 1ns/1ps
`default_nettype none
module ple_ms_tick #(
  parameter int CYCLES = ple_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst_b,
  // Millisecond pulse
  output logic      o_tick
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } ple_tick_st_t;

  ple_tick_st_t tick_ff;
  ple_tick_st_t nxt_tick;

  // Free running divider, one pulse per millisecond
  always_comb
  begin
    nxt_tick = tick_ff;
    nxt_tick.tick = 1'b0;
    if (tick_ff.cnt == 32'(CYCLES - 1))
    begin
      nxt_tick.cnt = 32'h0000_0000;
      nxt_tick.tick = 1'b1;
    end
    else
    begin
      nxt_tick.cnt = tick_ff.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tick_ff <= '0;
    end
    else
    begin
      tick_ff <= nxt_tick;
    end
  end

  assign o_tick = tick_ff.tick;

endmodule
`default_nettype wire

// *** hdl/ple_pick.sv ***
`timescale 1ns/1ps
`default_nettype none
module ple_pick (
  // Requests
  input  wire logic [63:0] i_req,
  input  wire logic [5:0]  i_start,
  // Result
  output logic             o_hit,
  output logic [5:0]       o_idx
);

  logic [127:0] dbl;
  logic [63:0]  rot;

  // Rotate so the search starts at i_start, first set bit wins
  always_comb
  begin
    dbl = {i_req, i_req} >> i_start;
    rot = dbl[63:0];
    o_hit = |rot;
    o_idx = 6'h00;
    for (int j = 63; j >= 0; j--)
    begin
      if (rot[j])
      begin
        o_idx = i_start + 6'(j);
      end
    end
  end

endmodule
`default_nettype wire

// *** pkg/ple_pkg.sv ***
package ple_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_NS         = 1_000_000;
  localparam int CYC_PER_MS    = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [14:0] PER_MIN_MS = 15'h00C8;  // 200 ms
  localparam logic [14:0] PER_MAX_MS = 15'h2710;  // 10 s
  localparam logic [14:0] TMR_MAX    = 15'h7FFF;

  // ----------------------------------------
  // Table limits
  // ----------------------------------------
  localparam int          N_ENTRY   = 64;
  localparam logic [6:0]  MAX_DIR   = 7'h20;  // 32 per direction
  localparam logic [7:0]  MAX_WORDS = 8'hC8;  // 200 words

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_SEL    = 12'h008;
  localparam logic [11:0] OFS_CFG    = 12'h00C;
  localparam logic [11:0] OFS_TIME   = 12'h010;
  localparam logic [11:0] OFS_STLO   = 12'h014;
  localparam logic [11:0] OFS_STHI   = 12'h018;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_EN      = 0;
  localparam int ST_RUN       = 0;
  localparam int ST_TRBL      = 1;
  localparam int ST_CFGERR    = 2;
  localparam int ST_NSEND_LSB = 8;
  localparam int ST_NRECV_LSB = 16;
  localparam int CFG_VLD      = 0;
  localparam int CFG_DIR      = 1;
  localparam int CFG_STN_LSB  = 2;
  localparam int CFG_BLK_LSB  = 8;
  localparam int CFG_AREA_LSB = 13;
  localparam int CFG_SIZE_LSB = 15;
  localparam int TIME_PER_LSB = 0;
  localparam int TIME_OFS_LSB = 16;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    CPU_RUN   = 2'h0,
    CPU_STOP  = 2'h1,
    CPU_PAUSE = 2'h2,
    CPU_DEBUG = 2'h3
  } ple_cpu_mode_t;

  typedef enum logic [1:0] {
    input_word_area    = 2'h0,
    output_word_area   = 2'h1,
    internal_word_area = 2'h2
  } ple_area_t;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [6:0] ple_popcount(input logic [63:0] v);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 0; i < 64; i++)
    begin
      c = c + {6'h00, v[i]};
    end
    return c;
  endfunction

  // Unset period falls back to the minimum; others clamp into range
  function automatic logic [14:0] ple_eff_period(input logic [13:0] p);
    logic [14:0] w;
    w = {1'b0, p};
    if (w < PER_MIN_MS)
    begin
      w = PER_MIN_MS;
    end
    else if (w > PER_MAX_MS)
    begin
      w = PER_MAX_MS;
    end
    return w;
  endfunction

endpackage

// *** testbench/ple_peer_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ple_peer_model (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  // Bench controls
  input  wire logic [15:0] i_scan_gap,
  input  wire logic [1:0]  i_tx_lat,
  input  wire logic        i_inj,
  input  wire logic [5:0]  i_inj_station,
  input  wire logic [4:0]  i_inj_block,
  input  wire logic [7:0]  i_inj_words,
  // Host scan and send side
  output logic             o_scan_end,
  input  wire logic        i_tx_valid,
  output logic             o_tx_ready,
  // Received headers
  output logic             o_rx_valid,
  output logic [5:0]       o_rx_station,
  output logic [4:0]       o_rx_block,
  output logic [7:0]       o_rx_words
);
  logic [15:0] scan_cnt_ff;
  logic [1:0]  wait_cnt_ff;

  // ----------------------------------------
  // Host CPU and peer stations
  // ----------------------------------------
  // Scan end every gap cycles, none while gap is 0
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      scan_cnt_ff  <= 16'h0000;
      wait_cnt_ff  <= 2'h0;
      o_scan_end   <= 1'b0;
      o_tx_ready   <= 1'b0;
      o_rx_valid   <= 1'b0;
      o_rx_station <= 6'h00;
      o_rx_block   <= 5'h00;
      o_rx_words   <= 8'h00;
    end
    else
    begin
      o_scan_end   <= (i_scan_gap != 16'h0000) && (scan_cnt_ff >= i_scan_gap - 16'h0001);
      scan_cnt_ff  <= (scan_cnt_ff >= i_scan_gap - 16'h0001) ? 16'h0000 : scan_cnt_ff + 16'h0001;
      // Slow or prompt acceptance of a send request
      o_tx_ready   <= i_tx_valid && !o_tx_ready && (wait_cnt_ff >= i_tx_lat);
      wait_cnt_ff  <= (i_tx_valid && !o_tx_ready) ? wait_cnt_ff + 2'h1 : 2'h0;
      // Header carries station and block; idle fields show inverted junk
      o_rx_valid   <= i_inj;
      o_rx_station <= i_inj ? i_inj_station : ~o_rx_station;
      o_rx_block   <= i_inj ? i_inj_block : ~o_rx_block;
      o_rx_words   <= i_inj ? i_inj_words : ~o_rx_words;
    end
  end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        i_clock, i_rst_b, psel, penable, pwrite, pready, pslverr, scan_end, err;
  logic        tx_valid, tx_ready, rx_valid, rx_hit, rx_drop, run_link, trouble, inj;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [15:0] scan_gap;
  logic [1:0]  cpu_mode, tx_lat, tx_area, rx_area;
  logic [5:0]  local_st, tx_st, rx_st, inj_st;
  logic [4:0]  tx_blk, rx_blk, inj_blk;
  logic [13:0] tx_ofs, rx_ofs;
  logic [7:0]  tx_words, rx_words, rx_keep, inj_w;
  logic [63:0] status;
  logic [34:0] tx_cap;
  int          num_errors = 0, num_checks = 0, cyc = 0, tx_n = 0, t_prev = 0, t_last = 0;
  localparam int MSC = 20;

  // ----------------------------------------
  // Clock, design and far side
  // ----------------------------------------
  initial
  begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  ple_link #(.MS_CYCLES(MSC)) u_dut (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_cpu_mode(cpu_mode), .i_scan_end(scan_end),
    .i_local_station(local_st), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready),
    .o_tx_station(tx_st), .o_tx_block(tx_blk), .o_tx_area(tx_area), .o_tx_offset(tx_ofs),
    .o_tx_words(tx_words), .i_rx_valid(rx_valid), .i_rx_station(rx_st),
    .i_rx_block(rx_blk), .i_rx_words(rx_words), .o_rx_hit(rx_hit), .o_rx_drop(rx_drop),
    .o_rx_area(rx_area), .o_rx_offset(rx_ofs), .o_rx_keep(rx_keep),
    .o_run_link(run_link), .o_link_trouble(trouble), .o_entry_status_bits(status));

  ple_peer_model u_peer (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_scan_gap(scan_gap), .i_tx_lat(tx_lat),
    .i_inj(inj), .i_inj_station(inj_st), .i_inj_block(inj_blk), .i_inj_words(inj_w),
    .o_scan_end(scan_end), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
    .o_rx_valid(rx_valid), .o_rx_station(rx_st), .o_rx_block(rx_blk), .o_rx_words(rx_words));

  // Record every send request the far side takes
  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      t_prev <= t_last;
      t_last <= cyc;
      tx_n   <= tx_n + 1;
      tx_cap <= {tx_st, tx_blk, tx_area, tx_ofs, tx_words};
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [31:0] cw(input logic d, input logic [5:0] s, input logic [4:0] b,
                                     input logic [1:0] a, input logic [7:0] n);
    return {9'h000, n, a, b, s, d, 1'b1};
  endfunction

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do
    begin
      @(posedge i_clock);
      n++;
    end
    while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1)
      num_errors++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic cfg(input logic [5:0] i, input logic [31:0] c, input logic [31:0] t);
    apb(1'b1, ple_pkg::OFS_SEL, {26'h000_0000, i});
    apb(1'b1, ple_pkg::OFS_CFG, c);
    apb(1'b1, ple_pkg::OFS_TIME, t);
  endtask

  task automatic rx(input logic [5:0] s, input logic [4:0] b, input logic [7:0] w,
                    output logic h, output logic d);
    inj    <= 1'b1;
    inj_st <= s;
    inj_blk <= b;
    inj_w  <= w;
    @(posedge i_clock);
    inj <= 1'b0;
    h = 1'b0;
    d = 1'b0;
    repeat (4)
    begin
      @(posedge i_clock);
      h = h | rx_hit;
      d = d | rx_drop;
    end
  endtask

  // Wait for n takes, a matching block every 1000 cycles meanwhile
  task automatic wait_tx(input int n);
    int k;
    k = 0;
    inj_st  <= 6'h03;
    inj_blk <= 5'h07;
    inj_w   <= 8'h04;
    while (tx_n < n && k < 30000)
    begin
      inj <= (k % 1000 == 999);
      @(posedge i_clock);
      k++;
    end
    inj <= 1'b0;
    @(posedge i_clock);
    if (tx_n < n)
      num_errors++;
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    // Tests need about 40k cycles
    repeat (60000) @(posedge i_clock);
    num_errors++;
    conclude();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    logic [5:0] s;
    logic [4:0] b;
    logic [7:0] w;
    logic       h, d, e;
    logic [18:0] tbl [5];
    tbl = '{{6'h03, 5'h07, 8'h04}, {6'h03, 5'h07, 8'h03}, {6'h03, 5'h07, 8'hC8},
            {6'h03, 5'h06, 8'h04}, {6'h02, 5'h07, 8'h04}};
    i_rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0000_0000; cpu_mode = ple_pkg::CPU_STOP; scan_gap = 16'h0000;
    tx_lat = 2'h0; inj = 1'b0; inj_st = 6'h00; inj_blk = 5'h00; inj_w = 8'h00;
    seed = 32'hc8e4_819d;
    local_st = seed[5:0];
    repeat (20) @(posedge i_clock);
    i_rst_b <= 1'b1;
    @(posedge i_clock);
    check(run_link, 1'b0);
    check(trouble, 1'b1);
    check(status, 64'h0);
    apb(1'b0, 12'h01C, 32'h0000_0000);
    check({err, rd}, {1'b1, 32'h0000_0000});
    $display("test reset done");
    // Entry 0 sends, entry 1 receives from station 3
    cfg(6'h00, cw(1'b0, 6'h00, 5'h05, 2'h1, 8'h0A), 32'h0123_0000);
    cfg(6'h01, cw(1'b1, 6'h03, 5'h07, 2'h2, 8'h04), 32'h0040_0000);
    apb(1'b0, ple_pkg::OFS_STATUS, 32'h0000_0000);
    check(rd, 32'h0001_0102);
    rx(6'h03, 5'h07, 8'h04, h, d);
    check({h, d}, 2'h0);
    cpu_mode <= ple_pkg::CPU_RUN;
    apb(1'b1, ple_pkg::OFS_CTRL, 32'h0000_0001);
    apb(1'b0, ple_pkg::OFS_CTRL, 32'h0000_0000);
    check(rd[0], 1'b0);
    cpu_mode <= ple_pkg::CPU_STOP;
    apb(1'b1, ple_pkg::OFS_CTRL, 32'h0000_0001);
    apb(1'b1, ple_pkg::OFS_TIME, 32'h0040_0000);
    apb(1'b0, ple_pkg::OFS_CTRL, 32'h0000_0000);
    check(rd[0], 1'b0);
    apb(1'b1, ple_pkg::OFS_CTRL, 32'h0000_0001);
    apb(1'b0, ple_pkg::OFS_CTRL, 32'h0000_0000);
    check(rd[0], 1'b1);
    cpu_mode <= ple_pkg::CPU_PAUSE;
    $display("test enable done");
    // Corner headers first, then random ones
    for (int k = 0; k < 12; k++)
    begin
      seed = nxt(seed);
      {s, b, w} = (k < 5) ? tbl[k] : {seed[0] ? 6'h03 : seed[6:1], seed[8] ? 5'h07 : seed[13:9],
                                      8'h01 + 8'(seed[23:16] % 200)};
      e = (s == 6'h03) && (b == 5'h07);
      rx(s, b, w, h, d);
      check({h, d}, {e, !e});
      if (e)
        check({rx_area, rx_ofs, rx_keep}, {2'h2, 14'h0040, (w < 8'h04) ? w : 8'h04});
    end
    $display("test receive done");
    scan_gap <= 16'd300;
    tx_lat <= 2'h2;
    wait_tx(1);
    check(tx_cap, {local_st, 5'h05, 2'h1, 14'h0123, 8'h0A});
    wait_tx(2);
    check((t_last - t_prev >= 3980) && (t_last - t_prev <= 4360), 1'b1);
    scan_gap <= 16'd6000;
    tx_lat <= 2'h0;
    wait_tx(5);
    check(t_last - t_prev, 6000);
    check(status[1:0], 2'h3);
    check({run_link, trouble}, 2'h2);
    $display("test send done");
    scan_gap <= 16'h0000;
    repeat (10000) @(posedge i_clock);
    check(status[1:0], 2'h0);
    check({run_link, trouble}, 2'h2);
    cpu_mode <= ple_pkg::CPU_STOP;
    apb(1'b1, ple_pkg::OFS_CTRL, 32'h0000_0000);
    repeat (3) @(posedge i_clock);
    check({run_link, trouble}, 2'h1);
    $display("test sticky done");
    for (int i = 0; i < 33; i++)
      cfg(6'(i), cw(1'b0, 6'h00, 5'(i), 2'h0, 8'h01), 32'h0000_0000);
    apb(1'b0, ple_pkg::OFS_STATUS, 32'h0000_0000);
    check(rd[14:0], 15'h2106);
    cfg(6'd32, 32'h0000_0000, 32'h0000_0000);
    apb(1'b0, ple_pkg::OFS_STATUS, 32'h0000_0000);
    check(rd[14:0], 15'h2002);
    $display("test limits done");
    conclude();
  end
endmodule
`default_nettype wire
